// File: design/sgw_page_walker.sv
/*
  scatter-gather page walker: takes one command image, issues one page
  transfer per data descriptor, fetches chained descriptor-list pages
  from host memory, then issues the separate metadata transfer.
  assumes a data mover on the xfer port, a qword memory reader on the
  list port, and a page size setting that is stable while busy.
*/
`timescale 1ns/1ps

module sgw_page_walker (
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  // configuration
  input  wire logic [sgw_pkg::MPS_W-1:0]  memoryPageSizeSetting,
  input  wire logic                       metaSeparate,
  // command in
  input  wire sgw_pkg::sgw_cmd_t          cmdIn,
  input  wire logic                       cmdValid,
  output logic                            cmdReady,
  // page transfers out
  output sgw_pkg::sgw_xfer_t              xferReq,
  output logic                            xferValid,
  input  wire logic                       xferReady,
  // descriptor-list reads
  output logic [sgw_pkg::ADDR_W-1:0]      memReqAddr,
  output logic                            memReqValid,
  input  wire logic                       memReqReady,
  input  wire logic [63:0]                memRspData,
  input  wire logic                       memRspValid,
  // metadata transfer out
  output logic [sgw_pkg::ADDR_W-1:0]      metaAddr,
  output logic [31:0]                     metaWords,
  output logic                            metaValid,
  input  wire logic                       metaReady,
  // command-specific handling and status
  output logic [127:0]                    cmdSpecificWords,
  output logic [31:0]                     namespaceSelector,
  output logic                            nsAll,
  output logic                            nsNone,
  output logic                            busy,
  output logic                            cmdDone
);

  // every property below samples on the rising clock and sleeps in reset
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // state
  typedef struct packed {
    sgw_pkg::sgw_state_t      fsm;
    sgw_pkg::sgw_state_t      after;
    logic [sgw_pkg::LEN_W-1:0] remBytes;
    logic [sgw_pkg::LEN_W-1:0] slotsLeft;
    logic [sgw_pkg::ADDR_W-1:0] cursor;
    sgw_pkg::sgw_cmd_t        cmd;
    logic                     cmdReady;
    sgw_pkg::sgw_xfer_t       xferReq;
    logic                     xferValid;
    logic [sgw_pkg::ADDR_W-1:0] memReqAddr;
    logic                     memReqValid;
    logic [sgw_pkg::ADDR_W-1:0] metaAddr;
    logic [31:0]              metaWords;
    logic                     metaValid;
    logic                     nsAll;
    logic                     nsNone;
    logic                     busy;
    logic                     cmdDone;
  } sgw_walk_t;
  sgw_walk_t stReg;
  sgw_walk_t stNext;

  // ==========================================================================
  // page arithmetic
  // page size in bytes for the current setting
  function automatic logic [sgw_pkg::LEN_W-1:0] pageBytes(
    input logic [sgw_pkg::MPS_W-1:0] mps
  );
    logic [sgw_pkg::LEN_W-1:0] one;
    one = sgw_pkg::LEN_W'(1);
    return one << (sgw_pkg::PAGE_MIN_SHIFT + 32'(mps));
  endfunction
  // offset bits n:2 of a descriptor, bits 1:0 dropped as reserved
  function automatic logic [sgw_pkg::LEN_W-1:0] pageOffset(
    input logic [sgw_pkg::ADDR_W-1:0] desc,
    input logic [sgw_pkg::MPS_W-1:0]  mps
  );
    logic [sgw_pkg::LEN_W-1:0] low;
    low = desc[sgw_pkg::LEN_W-1:0] & (pageBytes(mps) - sgw_pkg::LEN_W'(1));
    return {low[sgw_pkg::LEN_W-1:sgw_pkg::DWORD_SHIFT], 2'b00};
  endfunction
  function automatic logic [sgw_pkg::LEN_W-1:0] minLen(
    input logic [sgw_pkg::LEN_W-1:0] a,
    input logic [sgw_pkg::LEN_W-1:0] b
  );
    return (a < b) ? a : b;
  endfunction
  logic [sgw_pkg::LEN_W-1:0] pageLen;
  assign pageLen = pageBytes(memoryPageSizeSetting);

  // ==========================================================================
  // walker next state
  // one request outstanding on each port keeps ordering trivial, at the
  // cost of a round trip per list entry
  always_comb
  begin
    logic [sgw_pkg::LEN_W-1:0] chunk;
    logic [sgw_pkg::LEN_W-1:0] remAfter;
    chunk    = sgw_pkg::LEN_ZERO;
    remAfter = sgw_pkg::LEN_ZERO;
    stNext   = stReg;
    stNext.cmdDone = 1'b0;
    unique case (stReg.fsm)
      sgw_pkg::ST_IDLE:
      begin
        stNext.cmdReady = 1'b1;
        if (cmdValid && stReg.cmdReady)
        begin
          stNext.cmdReady = 1'b0;
          stNext.busy     = 1'b1;
          stNext.cmd      = cmdIn; // reserved bytes latched, never read
          stNext.remBytes = {6'h00, cmdIn.dataWordCount, 2'b00};
          stNext.nsAll    = (cmdIn.namespaceSelector == sgw_pkg::NS_ALL);
          stNext.nsNone   = (cmdIn.namespaceSelector == sgw_pkg::NS_NONE);
          stNext.fsm      = (cmdIn.dataWordCount == 32'h0000_0000) ?
                            sgw_pkg::ST_META : sgw_pkg::ST_FIRST;
        end
      end
      sgw_pkg::ST_FIRST:
      begin
        // start at the first descriptor's own offset, up to its page end
        chunk = pageLen - pageOffset(stReg.cmd.firstPageDescriptor,
                                     memoryPageSizeSetting);
        chunk = minLen(chunk, stReg.remBytes);
        remAfter = stReg.remBytes - chunk;
        stNext.xferReq.addr  = {stReg.cmd.firstPageDescriptor[63:2], 2'b00};
        stNext.xferReq.bytes = chunk;
        stNext.xferValid     = 1'b1;
        stNext.remBytes      = remAfter;
        stNext.fsm           = sgw_pkg::ST_XFER;
        if (remAfter == sgw_pkg::LEN_ZERO)
          stNext.after = sgw_pkg::ST_META;
        else if (remAfter <= pageLen)
          stNext.after = sgw_pkg::ST_SECOND;
        else
          stNext.after = sgw_pkg::ST_LIST_INIT;
      end
      sgw_pkg::ST_SECOND:
      begin
        stNext.xferReq.addr  = {stReg.cmd.secondPageDescriptor[63:2], 2'b00};
        stNext.xferReq.bytes = stReg.remBytes;
        stNext.xferValid     = 1'b1;
        stNext.remBytes      = sgw_pkg::LEN_ZERO;
        stNext.after         = sgw_pkg::ST_META;
        stNext.fsm           = sgw_pkg::ST_XFER;
      end
      sgw_pkg::ST_LIST_INIT:
      begin
        // list pointer is qword aligned and may start mid page
        stNext.cursor    = {stReg.cmd.secondPageDescriptor[63:3], 3'b000};
        stNext.slotsLeft = (pageLen - pageOffset(stReg.cmd.secondPageDescriptor,
                           memoryPageSizeSetting)) >> sgw_pkg::DESC_SHIFT;
        stNext.fsm       = sgw_pkg::ST_LIST_REQ;
      end
      sgw_pkg::ST_LIST_REQ:
      begin
        stNext.memReqAddr  = stReg.cursor;
        stNext.memReqValid = 1'b1;
        if (stReg.memReqValid && memReqReady)
        begin
          stNext.memReqValid = 1'b0;
          stNext.fsm         = sgw_pkg::ST_LIST_WAIT;
        end
      end
      sgw_pkg::ST_LIST_WAIT:
      begin
        if (memRspValid)
        begin
          if (stReg.slotsLeft == sgw_pkg::LEN_W'(1) && stReg.remBytes > pageLen)
          begin
            // final slot of a list page chains to the next list page while more than one page is still owed
            stNext.cursor    = {memRspData[63:3], 3'b000};
            stNext.slotsLeft = pageLen >> sgw_pkg::DESC_SHIFT;
            stNext.fsm       = sgw_pkg::ST_LIST_REQ;
          end
          else
          begin
            // count of entries follows from the bytes still owed
            chunk = minLen(stReg.remBytes, pageLen);
            remAfter = stReg.remBytes - chunk;
            stNext.xferReq.addr  = {memRspData[63:2], 2'b00};
            stNext.xferReq.bytes = chunk;
            stNext.xferValid     = 1'b1;
            stNext.remBytes      = remAfter;
            stNext.cursor        = stReg.cursor + 64'(sgw_pkg::DESC_BYTES);
            stNext.slotsLeft     = stReg.slotsLeft - sgw_pkg::LEN_W'(1);
            stNext.after         = (remAfter == sgw_pkg::LEN_ZERO) ?
                                   sgw_pkg::ST_META : sgw_pkg::ST_LIST_REQ;
            stNext.fsm           = sgw_pkg::ST_XFER;
          end
        end
      end
      sgw_pkg::ST_XFER:
      begin
        if (xferReady)
        begin
          stNext.xferValid = 1'b0;
          stNext.fsm       = stReg.after;
        end
      end
      sgw_pkg::ST_META:
      begin
        // interleaved metadata rides inside the data, so nothing to move here
        if (metaSeparate && stReg.cmd.metadataWordCount != 32'h0000_0000)
        begin
          stNext.metaAddr  = {stReg.cmd.metadataBufferPointer[63:2], 2'b00};
          stNext.metaWords = stReg.cmd.metadataWordCount;
          stNext.metaValid = 1'b1;
          stNext.fsm       = sgw_pkg::ST_META_WAIT;
        end
        else
          stNext.fsm = sgw_pkg::ST_DONE;
      end
      sgw_pkg::ST_META_WAIT:
      begin
        if (metaReady)
        begin
          stNext.metaValid = 1'b0;
          stNext.fsm       = sgw_pkg::ST_DONE;
        end
      end
      sgw_pkg::ST_DONE:
      begin
        stNext.cmdDone  = 1'b1;
        stNext.busy     = 1'b0;
        stNext.cmdReady = 1'b1;
        stNext.fsm      = sgw_pkg::ST_IDLE;
      end
    endcase
  end

  // ==========================================================================
  // state register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      stReg <= '0; // all flags low, idle, ready raised one cycle later
    else
      stReg <= stNext;
  end

  // ==========================================================================
  // outputs, each straight from the state register
  assign cmdReady          = stReg.cmdReady;
  assign xferReq           = stReg.xferReq;
  assign xferValid         = stReg.xferValid;
  assign memReqAddr        = stReg.memReqAddr;
  assign memReqValid       = stReg.memReqValid;
  assign metaAddr          = stReg.metaAddr;
  assign metaWords         = stReg.metaWords;
  assign metaValid         = stReg.metaValid;
  assign cmdSpecificWords  = {stReg.cmd.cmdSpecificWord15, stReg.cmd.cmdSpecificWord14,
                              stReg.cmd.cmdSpecificWord13, stReg.cmd.cmdSpecificWord12};
  assign namespaceSelector = stReg.cmd.namespaceSelector;
  assign nsAll             = stReg.nsAll;
  assign nsNone            = stReg.nsNone;
  assign busy              = stReg.busy;
  assign cmdDone           = stReg.cmdDone;

  // ==========================================================================
  // checks
  property p_meta_count;
    $rose(metaValid) |-> metaWords == stReg.cmd.metadataWordCount && metaAddr[1:0] == 2'b00;
  endproperty
  a_meta_count: assert property (p_meta_count) else $error("metadata count wrong");
  property p_no_overrun;
    $rose(xferValid) |-> xferReq.bytes != sgw_pkg::LEN_ZERO && xferReq.bytes <= pageLen;
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("transfer size out of range");
  property p_first_start;
    $past(stReg.fsm) == sgw_pkg::ST_FIRST |->
      xferReq.addr == {stReg.cmd.firstPageDescriptor[63:2], 2'b00};
  endproperty
  a_first_start: assert property (p_first_start) else $error("first page address wrong");
  property p_meta_gate;
    $rose(metaValid) |-> $past(metaSeparate);
  endproperty
  a_meta_gate: assert property (p_meta_gate) else $error("metadata moved when interleaved");
  property p_ns_flags;
    busy |-> nsAll == (namespaceSelector == sgw_pkg::NS_ALL) &&
             nsNone == (namespaceSelector == sgw_pkg::NS_NONE);
  endproperty
  a_ns_flags: assert property (p_ns_flags) else $error("namespace flags wrong");
  property p_qword_fetch;
    memReqValid |-> memReqAddr[2:0] == 3'b000;
  endproperty
  a_qword_fetch: assert property (p_qword_fetch) else $error("list fetch not qword aligned");
  property p_chain;
    stReg.fsm == sgw_pkg::ST_LIST_WAIT && memRspValid &&
    stReg.slotsLeft == sgw_pkg::LEN_W'(1) && stReg.remBytes > pageLen
    |=> !xferValid && stReg.fsm == sgw_pkg::ST_LIST_REQ ##1 memReqValid;
  endproperty
  a_chain: assert property (p_chain) else $error("list chain treated as data");
  property p_second_data;
    stReg.fsm == sgw_pkg::ST_SECOND |=>
      xferValid && xferReq.addr == {stReg.cmd.secondPageDescriptor[63:2], 2'b00};
  endproperty
  a_second_data: assert property (p_second_data) else $error("second slot not data");
  // a new command may be taken at the edge right after done, so look at done itself
  property p_done_empty;
    cmdDone |-> stReg.remBytes == sgw_pkg::LEN_ZERO && cmdReady && !busy;
  endproperty
  a_done_empty: assert property (p_done_empty) else $error("done with bytes owed");
  // main scenarios reached
  c_list_walk:  cover property (memRspValid && stReg.fsm == sgw_pkg::ST_LIST_WAIT);
  c_two_pages:  cover property (stReg.fsm == sgw_pkg::ST_SECOND);
  c_meta:       cover property (metaValid && metaReady);
  c_done:       cover property (cmdDone);
endmodule

// File: design/sgw_pkg.sv
/*
  shared types and constants of the scatter-gather page walker:
  the 64-byte command layout, page-size arithmetic and the walker states.
  assumes a 64-bit host address space and a 4-bit page size setting.
*/
package sgw_pkg;

  // ==========================================================================
  // sizes and page arithmetic
  localparam int unsigned ADDR_W         = 64;
  localparam int unsigned LEN_W          = 40;  // byte counts up to 4 x (2^32 - 1)
  localparam int unsigned MPS_W          = 4;
  localparam int unsigned PAGE_MIN_SHIFT = 12;  // setting 0 selects a 4KB page
  localparam int unsigned DESC_BYTES     = 8;   // one descriptor is one qword
  localparam int unsigned DESC_SHIFT     = 3;
  localparam int unsigned DWORD_SHIFT    = 2;

  // ==========================================================================
  // namespace selector codes
  localparam logic [31:0] NS_NONE = 32'h0000_0000;
  localparam logic [31:0] NS_ALL  = 32'hFFFF_FFFF;

  // ==========================================================================
  // command image, byte 0 in the least significant bits
  typedef struct packed {
    logic [31:0]       cmdSpecificWord15;    // bytes 63:60
    logic [31:0]       cmdSpecificWord14;    // bytes 59:56
    logic [31:0]       cmdSpecificWord13;    // bytes 55:52
    logic [31:0]       cmdSpecificWord12;    // bytes 51:48
    logic [31:0]       metadataWordCount;    // bytes 47:44
    logic [31:0]       dataWordCount;        // bytes 43:40
    logic [ADDR_W-1:0] secondPageDescriptor; // bytes 39:32
    logic [ADDR_W-1:0] firstPageDescriptor;  // bytes 31:24
    logic [ADDR_W-1:0] metadataBufferPointer;// bytes 23:16
    logic [63:0]       reservedBytes;        // bytes 15:08
    logic [31:0]       namespaceSelector;    // bytes 07:04
    logic [31:0]       commonCommandWord;    // bytes 03:00
  } sgw_cmd_t;

  // page transfer request handed to the data mover
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  bytes;
  } sgw_xfer_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_FIRST, ST_SECOND, ST_LIST_INIT, ST_LIST_REQ,
    ST_LIST_WAIT, ST_XFER, ST_META, ST_META_WAIT, ST_DONE
  } sgw_state_t;

  localparam logic [LEN_W-1:0] LEN_ZERO = '0;

endpackage

// File: dv/sgw_host_model.sv
/*
  host-side partner of the page walker: memory holding descriptor lists,
  a data mover and a metadata mover, all with random stalls.
  assumes the bench fills listMem before it offers each command.
*/
`timescale 1ns/1ps

module sgw_host_model (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // descriptor-list reads
  input  wire logic [63:0] memReqAddr,
  input  wire logic        memReqValid,
  output logic             memReqReady,
  output logic [63:0]      memRspData,
  output logic             memRspValid,
  // data and metadata movers
  output logic             xferReady,
  output logic             metaReady
);

  // ==========================================================================
  // host memory and read state
  logic [63:0] listMem [logic [63:0]];
  logic [63:0] pendAddr;
  logic        pending;
  int          waitCnt;

  initial
  begin
    {memReqReady, memRspValid, xferReady, metaReady, pending} = '0;
    memRspData = '0;
  end

  // one read outstanding; data outside a response flips so it is never stale
  always @(posedge core_clk)
  begin
    memRspValid <= 1'b0;
    memRspData  <= ~memRspData;
    xferReady   <= ($urandom % 3) != 0;
    metaReady   <= ($urandom % 2) != 0;
    memReqReady <= !pending && (($urandom % 2) != 0);
    if (sys_rst)
      pending <= 1'b0;
    else if (pending)
    begin
      if (waitCnt == 0)
      begin
        memRspValid <= 1'b1;
        memRspData  <= listMem.exists(pendAddr) ? listMem[pendAddr] : ~pendAddr;
        pending     <= 1'b0;
      end
      else
        waitCnt <= waitCnt - 1;
    end
    else if (memReqValid && memReqReady)
    begin
      pending  <= 1'b1;
      pendAddr <= memReqAddr;
      waitCnt  <= $urandom % 4;
    end
  end

endmodule

// File: dv/tb.sv
/*
  self-checking bench of the page walker: a queue model walks the same
  descriptors and is compared with every page and metadata transfer.
  assumes sgw_pkg and the host model are compiled first.
*/
`timescale 1ns/1ps

module tb;

  // ==========================================================================
  // signals
  logic                      core_clk = 1'b0;
  logic                      sys_rst  = 1'b1;
  logic [sgw_pkg::MPS_W-1:0] mps      = '0;
  logic                      metaSep  = 1'b0;
  logic                      cmdValid = 1'b0;
  sgw_pkg::sgw_cmd_t         cmd      = '0;
  sgw_pkg::sgw_xfer_t        xferReq;
  sgw_pkg::sgw_xfer_t        expQ[$];
  logic                      cmdReady, xferValid, xferReady, memReqValid, memReqReady;
  logic                      memRspValid, metaValid, metaReady, nsAll, nsNone, busy, cmdDone;
  logic [63:0]               memReqAddr, memRspData, metaAddr, expMetaAddr;
  logic [31:0]               metaWords, nsSel, expMetaWords;
  logic [127:0]              cmdWords;
  logic                      expMeta = 1'b0;
  int                        err_count = 0;
  int                        check_count = 0;
  int                        metaSeen = 0;

  always #10 core_clk = ~core_clk;

  sgw_page_walker i_sgw_page_walker (
    .core_clk(core_clk), .sys_rst(sys_rst), .memoryPageSizeSetting(mps),
    .metaSeparate(metaSep), .cmdIn(cmd), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .xferReq(xferReq), .xferValid(xferValid), .xferReady(xferReady),
    .memReqAddr(memReqAddr), .memReqValid(memReqValid), .memReqReady(memReqReady),
    .memRspData(memRspData), .memRspValid(memRspValid), .metaAddr(metaAddr),
    .metaWords(metaWords), .metaValid(metaValid), .metaReady(metaReady),
    .cmdSpecificWords(cmdWords), .namespaceSelector(nsSel), .nsAll(nsAll),
    .nsNone(nsNone), .busy(busy), .cmdDone(cmdDone));

  sgw_host_model i_sgw_host_model (
    .core_clk(core_clk), .sys_rst(sys_rst), .memReqAddr(memReqAddr),
    .memReqValid(memReqValid), .memReqReady(memReqReady), .memRspData(memRspData),
    .memRspValid(memRspValid), .xferReady(xferReady), .metaReady(metaReady));

  // ==========================================================================
  // checking and closing
  task automatic chk(input logic ok, input string msg);
  begin
    check_count++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  end
  endtask

  task automatic end_sim;
  begin
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask

  // every accepted transfer is compared at the edge that takes it
  always @(posedge core_clk)
  begin
    if (!sys_rst && xferValid && xferReady)
    begin
      chk(expQ.size() > 0 && xferReq === expQ[0], "page transfer");
      if (expQ.size() > 0)
        void'(expQ.pop_front());
    end
    if (!sys_rst && metaValid && metaReady)
    begin
      chk(expMeta && metaAddr === expMetaAddr && metaWords === expMetaWords, "metadata");
      metaSeen++;
    end
  end

  // ==========================================================================
  // model walk, list fill and one command
  task automatic run_cmd(input int m, input logic [63:0] first, input int unsigned dw,
                         input longint unsigned listOff, input logic sep,
                         input logic [31:0] ns);
    longint unsigned   page, rem, b, lp, dBase, lBase;
    sgw_pkg::sgw_cmd_t c;
    int                n;
  begin
    page  = 64'h1000 << m;
    rem   = longint'(dw) * 4;
    dBase = 64'h10_0000_0000;
    lBase = 64'h20_0000_0000;
    for (int i = 0; i < 16; i++)
      c[i*32 +: 32] = $urandom;
    c.namespaceSelector    = ns;
    c.dataWordCount        = dw;
    c.firstPageDescriptor  = first;
    c.metadataWordCount    = $urandom % 64;
    b = page - (first & (page - 1) & ~64'h3);
    if (b > rem)
      b = rem;
    if (rem > 0)
      expQ.push_back({first & ~64'h3, sgw_pkg::LEN_W'(b)});
    rem = rem - b;
    if (rem > 0 && rem <= page)
    begin
      c.secondPageDescriptor = dBase | 64'h3;
      expQ.push_back({dBase, sgw_pkg::LEN_W'(rem)});
      rem = 0;
    end
    else if (rem > 0)
    begin
      lp = lBase + listOff;
      c.secondPageDescriptor = lp;
      while (rem > 0)
      begin
        // the last slot of a page chains on while more than one page is left
        if ((page - (lp & (page - 1))) / 8 == 1 && rem > page)
        begin
          lBase = lBase + page;
          i_sgw_host_model.listMem[lp] = lBase;
          lp = lBase;
        end
        else
        begin
          dBase = dBase + page;
          i_sgw_host_model.listMem[lp] = dBase | 64'h3;
          b = (rem < page) ? rem : page;
          expQ.push_back({dBase, sgw_pkg::LEN_W'(b)});
          rem = rem - b;
          lp  = lp + 8;
        end
      end
    end
    expMeta      = sep && c.metadataWordCount != 0;
    expMetaAddr  = c.metadataBufferPointer & ~64'h3;
    expMetaWords = c.metadataWordCount;
    metaSeen     = 0;
    @(posedge core_clk);
    mps      <= sgw_pkg::MPS_W'(m);
    metaSep  <= sep;
    cmd      <= c;
    cmdValid <= 1'b1;
    n = 0;
    do
      @(posedge core_clk);
    while (!cmdReady && ++n < 50);
    cmdValid <= 1'b0;
    @(posedge core_clk);
    chk(busy === 1'b1 && cmdReady === 1'b0, "busy after accept");
    n = 0;
    while (cmdDone !== 1'b1 && n < 20000)
    begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 20000, "no completion");
    chk(busy === 1'b0 && cmdReady === 1'b1, "idle at done");
    chk(expQ.size() == 0, "transfer count");
    chk(metaSeen == (expMeta ? 1 : 0), "metadata count");
    chk(cmdWords === {c.cmdSpecificWord15, c.cmdSpecificWord14,
                      c.cmdSpecificWord13, c.cmdSpecificWord12}, "words");
    chk(nsSel === ns && nsAll === (ns == sgw_pkg::NS_ALL)
        && nsNone === (ns == sgw_pkg::NS_NONE), "namespace");
    expQ.delete();
  end
  endtask

  // ==========================================================================
  // main sequence: fixed corner cases, then random commands
  initial
  begin
    void'($urandom(81));
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    run_cmd(0, 64'h30_0000_0123, 0, 0, 1'b1, sgw_pkg::NS_NONE);
    run_cmd(0, 64'h30_0000_0F03, 2, 0, 1'b0, sgw_pkg::NS_ALL);
    run_cmd(1, 64'h30_0000_1800, 2560, 0, 1'b1, 32'h5);
    run_cmd(0, 64'h30_0000_0800, 5632, 64'hFF0, 1'b1, 32'h7);
    run_cmd(2, 64'h30_0000_0000, 20480, 64'h3FF8, 1'b0, 32'h1);
    for (int i = 0; i < 8; i++)
      run_cmd($urandom % 3, 64'h30_0000_0000 | ($urandom & 32'h1FFF), $urandom % 9000,
              ($urandom % 512) * 8, $urandom % 2, $urandom);
    end_sim;
  end

  // cut a hang short well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge core_clk);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim;
  end

endmodule
